/* File: ttrf_pkg.sv */
// Constants and types shared by the timestamp record formatter files
`default_nettype none

package ttrf_pkg;

  // ***********************************************************
  // Record layout
  // ***********************************************************
  localparam int unsigned TTRF_WORD_W = 64;
  localparam int unsigned TTRF_REC_W = 128;
  localparam int unsigned TTRF_SMP_W = 64;
  localparam int unsigned TTRF_TS40_W = 40;
  localparam int unsigned TTRF_SEC_W = 24;
  localparam int unsigned TTRF_EXTRA_W = 40;
  localparam int unsigned TTRF_PAD_W = TTRF_WORD_W - TTRF_EXTRA_W;

  // ***********************************************************
  // Extra data word fields (bit positions inside the 40-bit word)
  // ***********************************************************
  localparam int unsigned TTRF_OPT_LSB = 32;
  localparam int unsigned TTRF_OPT_W = 8;
  localparam int unsigned TTRF_BASE_LSB = 13;
  localparam int unsigned TTRF_BASE_W = 3;
  localparam int unsigned TTRF_SRC_CH0_BIT = 0;
  localparam int unsigned TTRF_SRC_CH_W = 4;
  localparam int unsigned TTRF_SRC_EXTERNAL_TRIGGER_INPUT0_BIT = 8;
  localparam int unsigned TTRF_SRC_EXTERNAL_TRIGGER_INPUT1_BIT = 9;
  localparam int unsigned TTRF_SRC_FORCE_BIT = 10;
  localparam int unsigned TTRF_SRC_BKP0_BIT = 16;
  localparam int unsigned TTRF_SRC_BKP_W = 8;
  localparam int unsigned TTRF_SRC_STAR_BIT = 24;
  localparam int unsigned TTRF_SRC_DSTAR_BIT = 25;

  // ***********************************************************
  // Bookkeeping widths and reset values
  // ***********************************************************
  localparam int unsigned TTRF_RECORDS_W = 16;
  localparam logic [TTRF_WORD_W-1:0] TTRF_RST_WORD = 64'h0000_0000_0000_0000;
  localparam logic [TTRF_RECORDS_W-1:0] TTRF_RST_RECORDS = 16'h0000;
  localparam logic [TTRF_RECORDS_W-1:0] TTRF_RECORD_STEP = 16'h0001;

  // ***********************************************************
  // Word sequencer states
  // ***********************************************************
  typedef enum logic [1:0] {
    TTRF_IDLE,
    TTRF_LOW,
    TTRF_HIGH
  } ttrf_phase_t;

  // Whole state of the top module
  typedef struct packed {
    ttrf_phase_t phase;
    logic [TTRF_WORD_W-1:0] upper_word;
    logic [TTRF_WORD_W-1:0] data;
    logic valid;
    logic running;
    logic stopped;
    logic lost;
    logic refclk_prev;
    logic [TTRF_RECORDS_W-1:0] records;
  } ttrf_top_state_t;

endpackage

`default_nettype wire

/* File: ttrf_cnt_if.sv */
// Carrier between the top module and one of its free-running counters
`timescale 1ns/100ps
`default_nettype none

interface ttrf_cnt_if #(
  parameter int unsigned W = 64
);
  logic inc;
  logic clr;
  logic [W-1:0] count;

  // Top module side: steers the counter and reads it
  modport owner (
    output inc,
    output clr,
    input count
  );

  // Counter side
  modport counter (
    input inc,
    input clr,
    output count
  );
endinterface

`default_nettype wire

/* File: ttrf_counter.sv */
// Clearable up-counter used for the sample clock and reference edge counts
`timescale 1ns/100ps
`default_nettype none

module ttrf_counter
  import ttrf_pkg::*;
#(
  parameter int unsigned WIDTH = 64
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  ttrf_cnt_if.counter cnt
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } ttrf_cnt_state_t;

  ttrf_cnt_state_t st_reg;
  ttrf_cnt_state_t st_next;

  // Clear beats increment so a reset command always lands on zero
  always_comb begin
    st_next = st_reg;
    if (cnt.clr) begin
      st_next.count = '0;
    end else if (cnt.inc) begin
      st_next.count = st_reg.count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // State register; wraps silently at full scale
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cnt.count = st_reg.count;

endmodule

`default_nettype wire

/* File: ttrf_top.sv */
// Timestamp record formatter: stamps triggers and pushes 128-bit records
//
// Summary of operation
// - 128-bit record sent as two words, low first
// - Low word counts sample clocks since reset
// - Counter captured when trigger is recognised internally
// - Standard format drives upper half to zero
// - Reference mode: 24-bit seconds over 40-bit stamp
// - Extended flag fills extra word, rest zero
// - No extended flag gives all-zero extra word
// - Digital capture samples input groups at trigger
// - No extra I/O option: bits 39..32 zero
// - Only the active input group is sampled
// - Source capture places backplane and local masks
// - Channel 0..3 sources set bits 1h..8h
// - External inputs 0 and 1 set 100h, 200h
// - Software force trigger sets bit 400h
// - Backplane variant sets lines, star, diff star
// - Format flags independent, fields coexist
// - FIFO overrun stops the transfer at once
`timescale 1ns/100ps
`default_nettype none

module ttrf_top
  import ttrf_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic TRIGGER_I,
  input wire logic COUNTER_RESET_I,
  input wire logic REFCLK_EDGE_I,
  input wire logic REFCLK_MODE_I,
  input wire logic DIGITAL_INPUT_CAPTURE_FLAG_I,
  input wire logic TRIGGER_SOURCE_CAPTURE_FLAG_I,
  input wire logic EXTRA_DIGITAL_IO_OPTION_I,
  input wire logic OPTIONAL_GROUP_ACTIVE_I,
  input wire logic [2:0] BASE_INPUT_GROUP_I,
  input wire logic [7:0] OPTIONAL_INPUT_GROUP_I,
  input wire logic [3:0] SOURCE_BIT_CHANNEL_I,
  input wire logic SOURCE_BIT_EXTERNAL0_I,
  input wire logic SOURCE_BIT_EXTERNAL1_I,
  input wire logic SOURCE_BIT_FORCED_I,
  input wire logic BACKPLANE_VARIANT_I,
  input wire logic [7:0] SOURCE_BIT_BACKPLANE_I,
  input wire logic SOURCE_BIT_STAR_LINE_I,
  input wire logic SOURCE_BIT_DIFF_STAR_LINE_I,
  input wire logic START_EXTRA_DMA_COMMAND_I,
  input wire logic FIFO_OVERRUN_I,
  input wire logic FIFO_READY_I,
  output logic [63:0] FIFO_DATA_O,
  output logic FIFO_VALID_O,
  output logic TRANSFER_ACTIVE_O,
  output logic TRANSFER_STOPPED_O,
  output logic TRIGGER_LOST_O,
  output logic [15:0] RECORDS_WRITTEN_O
);

  // ***********************************************************
  // Counters
  // ***********************************************************

  ttrf_cnt_if #(.W(TTRF_SMP_W)) smp_if ();
  ttrf_cnt_if #(.W(TTRF_SEC_W)) sec_if ();

  ttrf_top_state_t st_reg;
  ttrf_top_state_t st_next;

  // The block runs on the sampling clock, so every edge is one sample
  assign smp_if.inc = 1'b1;
  assign smp_if.clr = COUNTER_RESET_I;

  // Seconds counter advances on each rising reference edge
  assign sec_if.inc = REFCLK_EDGE_I & ~st_reg.refclk_prev;
  assign sec_if.clr = COUNTER_RESET_I;

  ttrf_counter #(
    .WIDTH(TTRF_SMP_W)
  ) u_smp_counter (
    .clk_i(SYS_CLK_I),
    .reset_n_i(RESET_N_I),
    .cnt(smp_if.counter)
  );

  ttrf_counter #(
    .WIDTH(TTRF_SEC_W)
  ) u_sec_counter (
    .clk_i(SYS_CLK_I),
    .reset_n_i(RESET_N_I),
    .cnt(sec_if.counter)
  );

  // ***********************************************************
  // Record assembly
  // ***********************************************************

  logic [TTRF_WORD_W-1:0] lower_word;
  logic [TTRF_WORD_W-1:0] upper_word;
  logic [TTRF_EXTRA_W-1:0] extra_word;
  logic [TTRF_SMP_W-1:0] smp_stamp;
  logic [TTRF_SEC_W-1:0] sec_stamp;

  // Counter values seen in the trigger cycle; a reset in that same
  // cycle already counts, so the stamp reads zero
  always_comb begin
    if (COUNTER_RESET_I) begin
      smp_stamp = '0;
      sec_stamp = '0;
    end else begin
      smp_stamp = smp_if.count;
      sec_stamp = sec_if.count;
    end
  end

  // Lower word: plain sample count, or seconds above a 40-bit stamp.
  // The 40-bit stamp wraps every few hours at high rates; software
  // extends it with the seconds field.
  always_comb begin
    if (REFCLK_MODE_I) begin
      lower_word = {sec_stamp, smp_stamp[TTRF_TS40_W-1:0]};
    end else begin
      lower_word = smp_stamp;
    end
  end

  // Extra word: each flag adds its own fields to a zero word, so the
  // two flags combine without interfering
  always_comb begin
    extra_word = '0;
    if (DIGITAL_INPUT_CAPTURE_FLAG_I) begin
      if (OPTIONAL_GROUP_ACTIVE_I) begin
        if (EXTRA_DIGITAL_IO_OPTION_I) begin
          extra_word[TTRF_OPT_LSB +: TTRF_OPT_W] = OPTIONAL_INPUT_GROUP_I;
        end
      end else begin
        extra_word[TTRF_BASE_LSB +: TTRF_BASE_W] = BASE_INPUT_GROUP_I;
      end
    end
    if (TRIGGER_SOURCE_CAPTURE_FLAG_I) begin
      extra_word[TTRF_SRC_CH0_BIT +: TTRF_SRC_CH_W] = SOURCE_BIT_CHANNEL_I;
      extra_word[TTRF_SRC_EXTERNAL_TRIGGER_INPUT0_BIT] = SOURCE_BIT_EXTERNAL0_I;
      extra_word[TTRF_SRC_EXTERNAL_TRIGGER_INPUT1_BIT] = SOURCE_BIT_EXTERNAL1_I;
      extra_word[TTRF_SRC_FORCE_BIT] = SOURCE_BIT_FORCED_I;
      // Backplane lines do not exist on other variants, keep them zero
      if (BACKPLANE_VARIANT_I) begin
        extra_word[TTRF_SRC_BKP0_BIT +: TTRF_SRC_BKP_W] = SOURCE_BIT_BACKPLANE_I;
        extra_word[TTRF_SRC_STAR_BIT] = SOURCE_BIT_STAR_LINE_I;
        extra_word[TTRF_SRC_DSTAR_BIT] = SOURCE_BIT_DIFF_STAR_LINE_I;
      end
    end
  end

  // Upper word: extra word in the low 40 bits, zero above; with no
  // flag set this is the all-zero standard format
  assign upper_word = {{TTRF_PAD_W{1'b0}}, extra_word};

  // ***********************************************************
  // Word sequencer and transfer control
  // ***********************************************************

  logic take_trigger;
  logic word_taken;

  // A trigger is stamped only while the transfer runs
  assign take_trigger = TRIGGER_I & st_reg.running & ~FIFO_OVERRUN_I;
  assign word_taken = st_reg.valid & FIFO_READY_I;

  // Next state. Low word goes first, upper word is held until the low
  // one is taken, so a record is never split by a later trigger.
  always_comb begin
    st_next = st_reg;
    st_next.refclk_prev = REFCLK_EDGE_I;

    // Start command arms the transfer and clears the loss flag
    if (START_EXTRA_DMA_COMMAND_I) begin
      st_next.running = 1'b1;
      st_next.stopped = 1'b0;
      st_next.lost = 1'b0;
    end

    unique case (st_reg.phase)
      TTRF_IDLE: begin
        if (take_trigger) begin
          st_next.data = lower_word;
          st_next.upper_word = upper_word;
          st_next.valid = 1'b1;
          st_next.phase = TTRF_LOW;
        end
      end
      TTRF_LOW: begin
        if (word_taken) begin
          st_next.data = st_reg.upper_word;
          st_next.phase = TTRF_HIGH;
        end
        if (take_trigger) begin
          st_next.lost = 1'b1;
        end
      end
      TTRF_HIGH: begin
        if (word_taken) begin
          st_next.records = st_reg.records + TTRF_RECORD_STEP;
          // Back to back: the next record may start as this one ends
          if (take_trigger) begin
            st_next.data = lower_word;
            st_next.upper_word = upper_word;
            st_next.phase = TTRF_LOW;
          end else begin
            st_next.valid = 1'b0;
            st_next.phase = TTRF_IDLE;
          end
        end else if (take_trigger) begin
          st_next.lost = 1'b1;
        end
      end
    endcase

    // Overrun wins over running, stopped, valid and phase, including a start in the same cycle.
    // Data already in the FIFO is suspect, so the pending record is
    // dropped rather than completed.
    if (FIFO_OVERRUN_I) begin
      st_next.running = 1'b0;
      st_next.stopped = 1'b1;
      st_next.valid = 1'b0;
      st_next.phase = TTRF_IDLE;
    end

    // A trigger lost in the cycle of a start is still reported
    if (TRIGGER_I & st_reg.running & (st_reg.phase != TTRF_IDLE) &
        ~(st_reg.phase == TTRF_HIGH & FIFO_READY_I)) begin
      st_next.lost = 1'b1;
    end
  end

  // ***********************************************************
  // State register
  // ***********************************************************

  // Reset returns to idle with the transfer not running and the stopped flag clear
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_reg.phase <= TTRF_IDLE;
      st_reg.upper_word <= TTRF_RST_WORD;
      st_reg.data <= TTRF_RST_WORD;
      st_reg.valid <= 1'b0;
      st_reg.running <= 1'b0;
      st_reg.stopped <= 1'b0;
      st_reg.lost <= 1'b0;
      st_reg.refclk_prev <= 1'b0;
      st_reg.records <= TTRF_RST_RECORDS;
    end else begin
      st_reg <= st_next;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************

  // All straight from the state register
  assign FIFO_DATA_O = st_reg.data;
  assign FIFO_VALID_O = st_reg.valid;
  assign TRANSFER_ACTIVE_O = st_reg.running;
  assign TRANSFER_STOPPED_O = st_reg.stopped;
  assign TRIGGER_LOST_O = st_reg.lost;
  assign RECORDS_WRITTEN_O = st_reg.records;

endmodule

`default_nettype wire

/* File: ttrf_chk_sva.sv */
// Port checker for the timestamp record formatter
`timescale 1ns/100ps
`default_nettype none
module ttrf_chk (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic TRIGGER_I,
  input wire logic START_EXTRA_DMA_COMMAND_I,
  input wire logic FIFO_OVERRUN_I,
  input wire logic FIFO_READY_I,
  input wire logic [63:0] FIFO_DATA_O,
  input wire logic FIFO_VALID_O,
  input wire logic TRANSFER_ACTIVE_O,
  input wire logic TRANSFER_STOPPED_O,
  input wire logic TRIGGER_LOST_O,
  input wire logic [15:0] RECORDS_WRITTEN_O
);
  // ***********************************************************
  // Word phase tracking
  // ***********************************************************
  logic hs;
  logic upper_q;
  assign hs = FIFO_VALID_O && FIFO_READY_I;
  // Overrun abandons the record, so the phase starts over
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      upper_q <= 1'b0;
    end else if (FIFO_OVERRUN_I) begin
      upper_q <= 1'b0;
    end else if (hs) begin
      upper_q <= !upper_q;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ***********************************************************
  // Record steps
  // ***********************************************************
  sequence trig_taken;
    TRIGGER_I && TRANSFER_ACTIVE_O && !FIFO_OVERRUN_I && !FIFO_VALID_O;
  endsequence
  sequence low_taken;
    hs && !upper_q && !FIFO_OVERRUN_I;
  endsequence
  sequence up_taken;
    hs && upper_q && !FIFO_OVERRUN_I;
  endsequence
  word_hold_a: assert property (FIFO_VALID_O && !FIFO_READY_I && !FIFO_OVERRUN_I |=>
    FIFO_VALID_O && $stable(FIFO_DATA_O)) else $error("word changed while stalled");
  stamp_latency_a: assert property (trig_taken |=> FIFO_VALID_O && !upper_q)
    else $error("low word not offered one cycle after trigger");
  upper_follows_a: assert property (low_taken |=> FIFO_VALID_O)
    else $error("upper word missing after low word");
  upper_pad_a: assert property (FIFO_VALID_O && upper_q |-> FIFO_DATA_O[63:40] == 24'h000000)
    else $error("upper word pad not zero");
  back_to_back_a: assert property (up_taken ##0 TRIGGER_I |=> FIFO_VALID_O)
    else $error("trigger at upper handoff lost");
  overrun_stop_a: assert property (FIFO_OVERRUN_I |=>
    !TRANSFER_ACTIVE_O && TRANSFER_STOPPED_O && (!FIFO_VALID_O)[*2])
    else $error("overrun did not stop transfer");
  start_arm_a: assert property (START_EXTRA_DMA_COMMAND_I && !FIFO_OVERRUN_I |=>
    TRANSFER_ACTIVE_O && !TRANSFER_STOPPED_O) else $error("start did not arm");
  lost_flag_a: assert property (TRIGGER_I && TRANSFER_ACTIVE_O && !FIFO_OVERRUN_I
    && FIFO_VALID_O && !(hs && upper_q) |=> TRIGGER_LOST_O) else $error("lost flag not set");
  record_count_a: assert property (up_taken |=>
    RECORDS_WRITTEN_O == $past(RECORDS_WRITTEN_O) + 16'h0001) else $error("record count");
endmodule
bind ttrf_top ttrf_chk u_chk (.SYS_CLK_I, .RESET_N_I, .TRIGGER_I, .START_EXTRA_DMA_COMMAND_I,
  .FIFO_OVERRUN_I, .FIFO_READY_I, .FIFO_DATA_O, .FIFO_VALID_O, .TRANSFER_ACTIVE_O,
  .TRANSFER_STOPPED_O, .TRIGGER_LOST_O, .RECORDS_WRITTEN_O);
`default_nettype wire

/* File: ttrf_sink_model.sv */
// Timestamp FIFO model that takes words promptly or with stalls
`timescale 1ns/100ps
`default_nettype none
module ttrf_sink_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic [1:0] tick_reg;
  // Slow mode takes one word in four, so words must stand meanwhile
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_reg <= 2'h0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
    end
  end
  assign ready_o = !slow_i || (tick_reg == 2'h3);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench of the timestamp record formatter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ttrf_pkg::*;
  logic clk, rst_n, trig, clr, refclk, refmode, dig, src, opt, optact, varnt;
  logic start, ovr, slow, ready, valid, active, stopped, lost;
  logic [2:0] base;
  logic [7:0] optin;
  logic [16:0] sb;
  logic [63:0] data;
  logic [15:0] recs;
  logic [63:0] words[$];
  int fails, samples_checked;
  ttrf_top u_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .TRIGGER_I(trig),
    .COUNTER_RESET_I(clr), .REFCLK_EDGE_I(refclk), .REFCLK_MODE_I(refmode),
    .DIGITAL_INPUT_CAPTURE_FLAG_I(dig), .TRIGGER_SOURCE_CAPTURE_FLAG_I(src),
    .EXTRA_DIGITAL_IO_OPTION_I(opt), .OPTIONAL_GROUP_ACTIVE_I(optact),
    .BASE_INPUT_GROUP_I(base), .OPTIONAL_INPUT_GROUP_I(optin),
    .SOURCE_BIT_CHANNEL_I(sb[3:0]), .SOURCE_BIT_EXTERNAL0_I(sb[4]),
    .SOURCE_BIT_EXTERNAL1_I(sb[5]), .SOURCE_BIT_FORCED_I(sb[6]),
    .BACKPLANE_VARIANT_I(varnt), .SOURCE_BIT_BACKPLANE_I(sb[14:7]),
    .SOURCE_BIT_STAR_LINE_I(sb[15]), .SOURCE_BIT_DIFF_STAR_LINE_I(sb[16]),
    .START_EXTRA_DMA_COMMAND_I(start), .FIFO_OVERRUN_I(ovr), .FIFO_READY_I(ready),
    .FIFO_DATA_O(data), .FIFO_VALID_O(valid), .TRANSFER_ACTIVE_O(active),
    .TRANSFER_STOPPED_O(stopped), .TRIGGER_LOST_O(lost), .RECORDS_WRITTEN_O(recs));
  ttrf_sink_model u_sink (.clk_i(clk), .reset_n_i(rst_n), .slow_i(slow), .ready_o(ready));
  // 40 MHz sampling clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  // Collect every word the FIFO accepts
  always @(posedge clk) begin
    if (valid === 1'b1 && ready === 1'b1) words.push_back(data);
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for n accepted words; polled off the clock edge
  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (words.size() < n && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (words.size() < n) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic pulse_start();
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    @(negedge clk);
  endtask
  // Clear counters, give nr reference rises, trigger d cycles after the clear
  task automatic stamp(input int d, input int nr);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    for (int k = 0; k < d; k++) begin
      refclk <= (k < 2 * nr) && (k % 2 == 0);
      @(posedge clk);
    end
    trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
  endtask
  // Expected upper word from the current flag and input settings
  function automatic logic [63:0] exp_up();
    logic [39:0] e;
    e = 40'h0;
    if (dig && optact) e[39:32] = opt ? optin : 8'h00;
    if (dig && !optact) e[15:13] = base;
    if (src) begin
      e[3:0] = sb[3:0];
      e[10:8] = sb[6:4];
      if (varnt) e[25:16] = sb[16:7];
    end
    return {24'h000000, e};
  endfunction
  initial begin
    {trig, clr, refclk, refmode, dig, src, opt, optact, varnt, start, ovr, slow} = 12'h000;
    {base, optin, sb} = 28'h0;
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    pulse_start();
    chk({63'h0, active}, 64'h1);
    // Every flag pairing except digital capture without source capture, both source patterns, prompt and stalled sink
    for (int i = 0; i < 17; i++) begin
      @(posedge clk);
      refmode <= i[0];
      dig <= i[1];
      optact <= i[2];
      slow <= i[2];
      opt <= !i[3];
      src <= (i != 0);
      varnt <= (i[1:0] != 2'h3);
      sb <= i[0] ? 17'h0AAAA : 17'h15555;
      base <= i[2:0];
      optin <= 8'hA5 ^ i[7:0];
      stamp(4 + i, i % 3);
      wait_words(2);
      chk(words[0], i[0] ? {24'(i % 3), 40'(4 + i)} : 64'(4 + i));
      chk(words[1], exp_up());
      words.delete();
    end
    @(negedge clk);
    chk({48'h0, recs}, 64'd17);
    // Trigger at the upper handoff starts the next record; clear in that cycle stamps zero
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    @(posedge clk);
    trig <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    clr <= 1'b0;
    wait_words(4);
    chk(words[2], 64'h0);
    chk({63'h0, lost}, 64'h0);
    words.delete();
    // Second trigger while the low word waits is dropped
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    wait_words(2);
    repeat (8) @(negedge clk);
    chk(64'(words.size()), 64'd2);
    chk({63'h0, lost}, 64'h1);
    words.delete();
    // Overrun in mid-record stops at once
    slow <= 1'b1;
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    @(posedge clk) ovr <= 1'b1;
    @(posedge clk) ovr <= 1'b0;
    @(negedge clk);
    chk({61'h0, valid, active, stopped}, 64'h1);
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    repeat (4) @(negedge clk);
    chk({63'h0, valid}, 64'h0);
    chk({48'h0, recs}, 64'd20);
    pulse_start();
    chk({61'h0, active, stopped, lost}, 64'h4);
    print_verdict();
  end
endmodule
`default_nettype wire
